// >>> hdl/slt_blocks.sv
`timescale 1ns/1ns
module slt_blocks
  import slt_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        scan_strobe,
  input  wire logic        power_fail,
  input  wire logic [3:0]  nor_in,
  input  wire logic [3:0]  nand_in,
  input  wire logic [3:0]  nand_conn,
  output logic             nor_out,
  output logic             edge_qualified_result,
  input  wire logic        on_trigger_input,
  input  wire logic [13:0] on_delay,
  input  wire logic [1:0]  on_unit,
  output logic             on_delay_timer,
  input  wire logic        off_trigger_input,
  input  wire logic        off_trigger_conn,
  input  wire logic        off_clear,
  input  wire logic        off_clear_conn,
  input  wire logic [13:0] off_delay,
  input  wire logic [1:0]  off_unit,
  output logic             off_delay_timer,
  input  wire logic        tog_trigger_input,
  input  wire logic        tog_trigger_conn,
  input  wire logic        tog_clear,
  input  wire logic        tog_clear_conn,
  output logic             toggle_relay,
  input  wire logic        latch_set,
  input  wire logic        latch_clear,
  output logic             set_clear_latch
);

  // ---------------------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------------------
  // Tick runs free; timer phase error stays below one tick (10 ms)
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic        tick;

  always_comb begin
    tick          = (tick_cnt == 32'(TICK_DIV - 1));
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) tick_cnt <= 32'h0;
    else         tick_cnt <= next_tick_cnt;
  end

  // ---------------------------------------------------------------------------
  // Scan evaluation
  // ---------------------------------------------------------------------------
  logic [3:0]  nand_eff;
  logic        off_trg;
  logic        off_rst;
  logic        tog_trg;
  logic        tog_rst;
  logic [3:0]  nand_prev;
  logic [2:0]  trig_prev;
  logic        started;
  logic [25:0] on_cnt;
  logic [25:0] off_cnt;
  logic        off_run;
  logic [25:0] on_limit;
  logic [25:0] off_limit;
  logic [3:0]  next_nand_prev;
  logic [2:0]  next_trig_prev;
  logic        next_started;
  logic [25:0] next_on_cnt;
  logic [25:0] next_off_cnt;
  logic        next_off_run;
  logic        next_nor_out;
  logic        next_eqr;
  logic        next_on_out;
  logic        next_off_out;
  logic        next_toggle;
  logic        next_latch;

  always_comb begin
    nand_eff  = nand_in | ~nand_conn;
    off_trg   = off_trigger_input & off_trigger_conn;
    off_rst   = off_clear & off_clear_conn;
    tog_trg   = tog_trigger_input & tog_trigger_conn;
    tog_rst   = tog_clear & tog_clear_conn;
    // Delay held in hundredths; scaled to ticks by unit
    on_limit  = 26'(slt_clamp(on_delay)) * 26'(slt_scale(on_unit));
    off_limit = 26'(slt_clamp(off_delay)) * 26'(slt_scale(off_unit));

    next_nand_prev = nand_prev;
    next_trig_prev = trig_prev;
    next_started   = started;
    next_on_cnt    = on_cnt;
    next_off_cnt   = off_cnt;
    next_off_run   = off_run;
    next_nor_out   = nor_out;
    next_eqr       = edge_qualified_result;
    next_on_out    = on_delay_timer;
    next_off_out   = off_delay_timer;
    next_toggle    = toggle_relay;
    next_latch     = set_clear_latch;

    if (scan_strobe) begin
      next_nor_out = ~|nor_in;
      next_eqr     = (&nand_prev) & ~(&nand_eff);
      next_nand_prev = nand_eff;
      next_trig_prev = {tog_trg, off_trg, on_trigger_input};
      next_started   = 1'b1;

      // On-delay
      if (!on_trigger_input) begin
        next_on_cnt = 26'h0;
        next_on_out = 1'b0;
      end else if (!trig_prev[0]) begin
        next_on_cnt = 26'h0;
      end else if (on_cnt >= on_limit) begin
        next_on_out = 1'b1;
      end

      // Off-delay
      if (off_rst) begin
        next_off_out = 1'b0;
        next_off_run = 1'b0;
        next_off_cnt = 26'h0;
      end else if (off_trg) begin
        next_off_out = 1'b1;
        next_off_run = 1'b0;
        next_off_cnt = 26'h0;
      end else if (trig_prev[1]) begin
        next_off_run = 1'b1;
        next_off_cnt = 26'h0;
      end else if (off_run && off_cnt >= off_limit) begin
        next_off_out = 1'b0;
        next_off_run = 1'b0;
        next_off_cnt = 26'h0;
      end

      // Toggle: first scan sees previous trigger as low
      if (tog_rst) begin
        next_toggle = 1'b0;
      end else if (tog_trg && (!trig_prev[2] || !started)) begin
        next_toggle = ~toggle_relay;
      end

      if (latch_clear)     next_latch = 1'b0;
      else if (latch_set)  next_latch = 1'b1;
    end

    // Timers advance on ticks between scans
    if (tick) begin
      if (on_trigger_input && on_cnt < on_limit) next_on_cnt = next_on_cnt + 26'h1;
      if (off_run && off_cnt < off_limit)        next_off_cnt = next_off_cnt + 26'h1;
    end

    if (power_fail) begin
      next_toggle = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nand_prev             <= NAND_PREV_INIT;
      trig_prev             <= EDGE_PREV_INIT;
      started               <= 1'b0;
      on_cnt                <= 26'h0;
      off_cnt               <= 26'h0;
      off_run               <= 1'b0;
      nor_out               <= 1'b0;
      edge_qualified_result <= 1'b0;
      on_delay_timer        <= 1'b0;
      off_delay_timer       <= 1'b0;
      toggle_relay          <= 1'b0;
      set_clear_latch       <= 1'b0;
    end else begin
      nand_prev             <= next_nand_prev;
      trig_prev             <= next_trig_prev;
      started               <= next_started;
      on_cnt                <= next_on_cnt;
      off_cnt               <= next_off_cnt;
      off_run               <= next_off_run;
      nor_out               <= next_nor_out;
      edge_qualified_result <= next_eqr;
      on_delay_timer        <= next_on_out;
      off_delay_timer       <= next_off_out;
      toggle_relay          <= next_toggle;
      set_clear_latch       <= next_latch;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_on_low;
    scan_strobe && !on_trigger_input;
  endsequence

  a_nor_output: assert property (@(posedge core_clk) disable iff (sys_rst)
    scan_strobe |=> nor_out == ~|$past(nor_in))
    else $error("nor output wrong");

  a_on_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_on_low |=> !on_delay_timer && on_cnt == 26'h0)
    else $error("on delay not cleared");

  a_on_rise_cause: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(on_delay_timer) |-> $past(on_trigger_input) && $past(on_cnt) >= $past(on_limit))
    else $error("on delay rose early");

  a_off_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
    scan_strobe && off_trg && !off_rst |=> off_delay_timer)
    else $error("off delay not set");

  a_off_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
    scan_strobe && off_rst |=> !off_delay_timer && !off_run)
    else $error("off delay reset ignored");

  a_off_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
    scan_strobe && !off_rst && !off_trg && trig_prev[1] |=> off_run && off_cnt == 26'h0)
    else $error("off delay not restarted");

  a_toggle_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
    scan_strobe && tog_rst |=> !toggle_relay)
    else $error("toggle reset ignored");

  a_toggle_flip: assert property (@(posedge core_clk) disable iff (sys_rst)
    scan_strobe && !tog_rst && !power_fail && tog_trg && !trig_prev[2]
      |=> toggle_relay != $past(toggle_relay))
    else $error("toggle did not flip");

  a_latch_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    scan_strobe && latch_clear |=> !set_clear_latch)
    else $error("latch reset lost");

  a_latch_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(scan_strobe && (latch_set || latch_clear)) |=> $stable(set_clear_latch))
    else $error("latch changed without input");

  a_edge_nand: assert property (@(posedge core_clk) disable iff (sys_rst)
    scan_strobe |=> edge_qualified_result == (&$past(nand_prev) && !(&$past(nand_eff))))
    else $error("edge nand wrong");

  sequence s_on_ready;
    scan_strobe && on_trigger_input && trig_prev[0] && on_cnt >= on_limit;
  endsequence

  sequence s_off_expire;
    scan_strobe && !off_rst && !off_trg && !trig_prev[1] && off_run && off_cnt >= off_limit;
  endsequence

  // First scan after reset: stored trigger history is not trusted
  sequence s_tog_first;
    scan_strobe && !started && tog_trg && !tog_rst && !power_fail;
  endsequence

  a_on_rise: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_on_ready |=> on_delay_timer)
    else $error("on delay did not rise");

  a_off_expire: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_off_expire |=> !off_delay_timer && !off_run && off_cnt == 26'h0)
    else $error("off delay did not expire");

  a_toggle_start: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_tog_first |=> toggle_relay)
    else $error("toggle missed start edge");

  a_toggle_power: assert property (@(posedge core_clk) disable iff (sys_rst)
    power_fail |=> !toggle_relay)
    else $error("toggle kept after power event");

  a_latch_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    scan_strobe && latch_set && !latch_clear |=> set_clear_latch)
    else $error("latch set lost");

  a_edge_unconn: assert property (@(posedge core_clk) disable iff (sys_rst)
    scan_strobe && (&nand_prev) && (&(nand_in | ~nand_conn)) |=> !edge_qualified_result)
    else $error("unconnected nand input not high");

  // Timers run between scans, but only toggle_relay (on power_fail) may move without a scan
  a_scan_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !scan_strobe |=> $stable(nor_out) && $stable(edge_qualified_result)
      && $stable(on_delay_timer) && $stable(off_delay_timer))
    else $error("output moved between scans");

endmodule

// >>> hdl/slt_pkg.sv
package slt_pkg;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          TICK_PERIOD_MS = 10;
  localparam int          TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [13:0] DELAY_MIN      = 14'h0001;
  localparam logic [13:0] DELAY_MAX      = 14'h270f;
  localparam logic [13:0] DELAY_RESET    = 14'h0064;
  localparam logic [1:0]  UNIT_RESET     = 2'h0;
  localparam logic [2:0]  EDGE_PREV_INIT = 3'h0;
  localparam logic [3:0]  NAND_PREV_INIT = 4'h0;

  // ---------------------------------------------------------------------------
  // Time units
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SLT_UNIT_SEC  = 2'h0,
    SLT_UNIT_MIN  = 2'h1,
    SLT_UNIT_HOUR = 2'h2
  } slt_unit_t;

  localparam logic [11:0] SCALE_SEC  = 12'h001;
  localparam logic [11:0] SCALE_MIN  = 12'h03c;
  localparam logic [11:0] SCALE_HOUR = 12'he10;

  // Hundredth-second ticks per delay step for the chosen unit
  function automatic logic [11:0] slt_scale(input logic [1:0] unit);
    case (unit)
      SLT_UNIT_MIN:  slt_scale = SCALE_MIN;
      SLT_UNIT_HOUR: slt_scale = SCALE_HOUR;
      default:       slt_scale = SCALE_SEC;
    endcase
  endfunction

  function automatic logic [13:0] slt_clamp(input logic [13:0] d);
    if (d < DELAY_MIN) slt_clamp = DELAY_MIN;
    else if (d > DELAY_MAX) slt_clamp = DELAY_MAX;
    else slt_clamp = d;
  endfunction
endpackage

// >>> bench/slt_points.sv
`timescale 1ns/1ns
// ------------------------------
// Random input points
// ------------------------------
module slt_points (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       scan_strobe,
  output logic [3:0]      nor_in,
  output logic            latch_set,
  output logic            latch_clear
);
  int seed = 86;

  // New values land just after the scan that took the old ones
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nor_in <= 4'h0;
      latch_set <= 1'b0;
      latch_clear <= 1'b0;
    end else if (scan_strobe) begin
      nor_in <= 4'($random(seed));
      latch_set <= 1'($random(seed));
      latch_clear <= 1'($random(seed));
    end
  end
endmodule

// >>> bench/scan_logic_timer_latch_blocks_test.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %b seen %b", nm, e, g); end end
module scan_logic_timer_latch_blocks_test;
  import slt_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst, scan_strobe, power_fail, pend, lat_q;
  logic [3:0] nor_in, nand_in, nand_conn;
  logic [13:0] on_delay, off_delay;
  logic [1:0] on_unit, off_unit;
  logic on_trigger_input, off_trigger_input, off_trigger_conn, off_clear, off_clear_conn;
  logic tog_trigger_input, tog_trigger_conn, tog_clear, tog_clear_conn;
  logic latch_set, latch_clear, nor_out, edge_qualified_result;
  logic on_delay_timer, off_delay_timer, toggle_relay, set_clear_latch;
  logic [11:0] expq[$];
  logic [11:0] ent;
  int fails = 0;
  int check_count = 0;
  int scl[4];

  always #4 core_clk = ~core_clk;

  slt_blocks #(.TICK_DIV(4)) uut (
    .core_clk, .sys_rst, .scan_strobe, .power_fail, .nor_in, .nand_in, .nand_conn,
    .nor_out, .edge_qualified_result, .on_trigger_input, .on_delay, .on_unit,
    .on_delay_timer, .off_trigger_input, .off_trigger_conn, .off_clear, .off_clear_conn,
    .off_delay, .off_unit, .off_delay_timer, .tog_trigger_input, .tog_trigger_conn,
    .tog_clear, .tog_clear_conn, .toggle_relay, .latch_set, .latch_clear, .set_clear_latch
  );

  slt_points points (
    .core_clk, .sys_rst, .scan_strobe, .nor_in, .latch_set, .latch_clear
  );

  // ------------------------------
  // Scan driver and result watcher
  // ------------------------------
  // Mask and expectation order: edge nand, on-delay, off-delay, toggle
  task automatic scan(input logic [3:0] m, input logic [3:0] e);
    @(posedge core_clk);
    scan_strobe <= 1'b1;
    lat_q = latch_clear ? 1'b0 : (latch_set ? 1'b1 : lat_q);
    expq.push_back({1'b1, m, 1'b1, (nor_in == 4'h0), e, lat_q});
    @(posedge core_clk);
    scan_strobe <= 1'b0;
  endtask

  always @(posedge core_clk) pend <= scan_strobe;

  always @(negedge core_clk) begin
    if (pend && expq.size() > 0) begin
      ent = expq.pop_front();
      `CHK("nor_out", ent[5], nor_out)
      if (ent[10]) `CHK("edge_qualified_result", ent[4], edge_qualified_result)
      if (ent[9]) `CHK("on_delay_timer", ent[3], on_delay_timer)
      if (ent[8]) `CHK("off_delay_timer", ent[2], off_delay_timer)
      if (ent[7]) `CHK("toggle_relay", ent[1], toggle_relay)
      `CHK("set_clear_latch", ent[0], set_clear_latch)
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Longest step is the hour-unit delay, about 58k cycles
  initial begin
    repeat (80000) @(posedge core_clk);
    fails++;
    end_of_test();
  end

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    scl = '{int'(SCALE_SEC), int'(SCALE_MIN), int'(SCALE_HOUR), int'(SCALE_SEC)};
    sys_rst = 1'b1;
    {scan_strobe, power_fail, lat_q, on_trigger_input, off_trigger_input} = '0;
    {off_clear, tog_trigger_input, tog_clear} = '0;
    {off_trigger_conn, off_clear_conn, tog_trigger_conn, tog_clear_conn} = 4'hf;
    nand_in = 4'h0;
    nand_conn = 4'hf;
    on_delay = 14'h0004;
    off_delay = 14'h0005;
    on_unit = 2'h0;
    off_unit = 2'h0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    tog_trigger_input <= 1'b1;
    nand_in <= 4'hf;
    scan(4'hf, 4'h1);
    nand_in <= 4'he;
    tog_trigger_input <= 1'b0;
    scan(4'h9, 4'h9);
    tog_trigger_input <= 1'b1;
    scan(4'h9, 4'h0);
    nand_in <= 4'hf;
    tog_trigger_input <= 1'b0;
    scan(4'h9, 4'h0);
    tog_trigger_input <= 1'b1;
    tog_clear <= 1'b1;
    scan(4'h1, 4'h0);
    tog_trigger_input <= 1'b0;
    tog_clear_conn <= 1'b0;
    scan(4'h1, 4'h0);
    tog_trigger_input <= 1'b1;
    scan(4'h1, 4'h1);
    tog_clear <= 1'b0;
    tog_clear_conn <= 1'b1;
    power_fail <= 1'b1;
    @(posedge core_clk);
    power_fail <= 1'b0;
    scan(4'h1, 4'h0);
    tog_trigger_conn <= 1'b0;
    nand_in <= 4'h0;
    nand_conn <= 4'h0;
    scan(4'h9, 4'h0);
    tog_trigger_conn <= 1'b1;
    nand_conn <= 4'h1;
    scan(4'h9, 4'h9);
    off_trigger_input <= 1'b1;
    scan(4'h2, 4'h2);
    off_trigger_input <= 1'b0;
    scan(4'h2, 4'h2);
    repeat (8) @(posedge core_clk);
    off_trigger_input <= 1'b1;
    scan(4'h2, 4'h2);
    off_trigger_input <= 1'b0;
    scan(4'h2, 4'h2);
    repeat (12) @(posedge core_clk);
    scan(4'h2, 4'h2);
    repeat (30) @(posedge core_clk);
    scan(4'h2, 4'h0);
    off_trigger_input <= 1'b1;
    off_clear <= 1'b1;
    scan(4'h2, 4'h0);
    off_clear <= 1'b0;
    off_trigger_conn <= 1'b0;
    on_trigger_input <= 1'b1;
    scan(4'h6, 4'h0);
    off_trigger_conn <= 1'b1;
    repeat (8) @(posedge core_clk);
    on_trigger_input <= 1'b0;
    scan(4'h4, 4'h0);
    on_trigger_input <= 1'b1;
    scan(4'h4, 4'h0);
    repeat (8) @(posedge core_clk);
    scan(4'h4, 4'h0);
    // Off-delay shares the on-delay span so each unit code 0 to 3 is timed once (code 3 times seconds again)
    off_delay <= 14'h0004;
    for (int u = 0; u < 4; u++) begin
      on_unit <= 2'(u);
      off_unit <= 2'(u);
      on_trigger_input <= 1'b0;
      off_trigger_input <= 1'b1;
      scan(4'h6, 4'h2);
      on_trigger_input <= 1'b1;
      off_trigger_input <= 1'b0;
      scan(4'h6, 4'h2);
      repeat (16 * scl[u] - 16) @(posedge core_clk);
      scan(4'h6, 4'h2);
      repeat (24) @(posedge core_clk);
      scan(4'h6, 4'h4);
    end
    repeat (2) @(posedge core_clk);
    end_of_test();
  end
endmodule
